/* verilog/safety_pkg.sv */
// constants, addresses and state codes of the safety state controller
package safety_pkg;

  // clock and timing figures
  localparam int CLK_HZ = 100_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int INTERLOCK_MS = 200;
  localparam int ENERGIZE_LIMIT_MS = 100;
  localparam int SWITCH_ON_MS = 500;
  localparam int SYNC_MS = 50;
  localparam int INTERLOCK_CYC = INTERLOCK_MS * CYC_PER_MS;
  localparam int ENERGIZE_LIMIT_CYC = ENERGIZE_LIMIT_MS * CYC_PER_MS;
  localparam int SWITCH_ON_CYC = SWITCH_ON_MS * CYC_PER_MS;
  localparam int SYNC_CYC = SYNC_MS * CYC_PER_MS;

  // register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;

  // configuration fields
  localparam int CFG_W = 3;
  localparam int CFG_AUTO = 0;
  localparam int CFG_INTERLOCK = 1;
  localparam int CFG_SYNC = 2;
  localparam logic [2:0] CFG_RESET = 3'h0;

  // interrupt events
  localparam int NUM_EV = 5;
  localparam int EV_TRIP = 0;
  localparam int EV_ERROR = 1;
  localparam int EV_REJECT = 2;
  localparam int EV_ENERGIZE = 3;
  localparam int EV_INTERLOCK = 4;
  localparam logic [4:0] MASK_RESET = 5'h00;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // input synchroniser reset level
  localparam logic [6:0] PINS_RESET = 7'h00;

  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_INIT = 5'h02,
    ST_RUN_OFF = 5'h04,
    ST_RUN_ON = 5'h08,
    ST_ERROR = 5'h10
  } op_state_t;

endpackage

/* verilog/pin_sync.sv */
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 7,
  parameter logic [W-1:0] RST_VAL = '0
)(
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic [W-1:0] d, // asynchronous pin levels
  output logic [W-1:0] q // synchronised levels
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;

  sync_state_t cur, next_sync;

  // first stage feeds only the second stage
  always_comb begin
    next_sync.s1 = d;
    next_sync.s2 = cur.s1;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cur <= '{s1: RST_VAL, s2: RST_VAL};
    end else begin
      cur <= next_sync;
    end
  end

  assign q = cur.s2;

endmodule
`default_nettype wire

/* verilog/window_timer.sv */
// run-time window timer: flags once run has held for CYC cycles
`timescale 1ns/1ps
`default_nettype none
module window_timer #(
  parameter int CYC = 16
)(
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic run, // count while high, clear while low
  output logic expired // high once run held CYC cycles
);

  localparam int W = $clog2(CYC + 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic done;
  } timer_state_t;

  timer_state_t cur, next_tmr;

  // restart on every drop of run so windows never accumulate
  always_comb begin
    next_tmr = cur;
    if (!run) begin
      next_tmr = '0;
    end else if (cur.cnt == W'(CYC - 1)) begin
      next_tmr.done = 1'b1;
    end else begin
      next_tmr.cnt = cur.cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_tmr;
    end
  end

  assign expired = cur.done;

endmodule
`default_nettype wire

/* verilog/safety_state_ctrl.sv */
// operating-state controller of a safety relay with AXI4-Lite registers
//
// Function
// R1: configuration writes accepted only in off state, rejected elsewhere
// R2: safety output energized only in run-energized state
// R3: on power up enter initialization and run self-tests
// R4: leave initialization when self-tests pass and switch-on delay expired
// R5: energize only with start condition met and safety inputs activated
// R6: with interlock monitoring, interlock condition blocks energizing
// R7: with synchronization, channels must activate within synchronization time
// R8: deactivated inputs in run-energized de-energize and return to run-off
// R9: detected error enters error state with outputs safe
// R10: on entering run-off, sample inputs before any decision
// R11: start input deactivated keeps device in run-off
// R12: start pressed with inputs deactivated keeps outputs off
// R13: after trip, fresh start and input reactivation both needed
// R14: power loss from any state returns to off, outputs off
// R15: error state left only through a power cycle
// R16: input activated when open channel reads 0, closed reads 1
// R17: output energized within 100 ms of valid conditions
// R18: channels deactivating further apart than 200 ms flag interlock
`timescale 1ns/1ps
`default_nettype none
module safety_state_ctrl #(
  parameter int SWITCH_ON_CYC = safety_pkg::SWITCH_ON_CYC,
  parameter int SYNC_CYC = safety_pkg::SYNC_CYC,
  parameter int INTERLOCK_CYC = safety_pkg::INTERLOCK_CYC
)(
  input wire logic ref_clk, // 100 MHz system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic [safety_pkg::ADDR_W-1:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [safety_pkg::ADDR_W-1:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic power_good, // supply present pin
  input wire logic selftest_done, // self-test finished pin
  input wire logic selftest_pass, // self-test result pin
  input wire logic error_detect, // internal fault pin
  input wire logic normally_open_channel, // contact channel, 0 = active
  input wire logic normally_closed_channel, // contact channel, 1 = active
  input wire logic start_in, // start pushbutton pin
  output logic safety_out, // safety output, high = energized
  output logic irq // level interrupt
);
  import safety_pkg::*;

  typedef struct packed {
    op_state_t st;
    logic out_on;
    logic [CFG_W-1:0] cfg;
    logic [NUM_EV-1:0] ev;
    logic [NUM_EV-1:0] mask;
    logic entry;
    logic start_prev;
    logic start_armed;
    logic pair;
    logic ilock;
    logic sync_fail;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] aw;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ctl_t;

  ctl_t cur, next_ctl;
  logic [6:0] pins_s;
  logic pg, st_done, st_pass, err, no_s, nc_s, start_s;
  logic ch_a, ch_b, act, start_ok, go, wr_fire;
  logic sw_exp, sync_exp, ilock_exp;
  logic [NUM_EV-1:0] ev_set, ev_clr;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisation and channel decode

  pin_sync #(.W(7), .RST_VAL(PINS_RESET)) u_pins (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d({power_good, selftest_done, selftest_pass, error_detect,
        normally_open_channel, normally_closed_channel, start_in}),
    .q(pins_s)
  );

  // unpack synchronised pins
  assign {pg, st_done, st_pass, err, no_s, nc_s, start_s} = pins_s;
  assign ch_a = !no_s; // R16
  assign ch_b = nc_s; // R16
  assign act = ch_a && ch_b; // R16

  ////////////////////////////////////////////////////////////////////////
  // timers: switch-on delay, activation sync window, interlock window

  window_timer #(.CYC(SWITCH_ON_CYC)) u_switch_on (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run(cur.st == ST_INIT),
    .expired(sw_exp)
  );

  // a lone active channel before the pair completes is an activation skew
  window_timer #(.CYC(SYNC_CYC)) u_sync_win (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run(!cur.pair && (ch_a ^ ch_b)),
    .expired(sync_exp)
  );

  // a lone active channel after the pair was up is a deactivation skew
  window_timer #(.CYC(INTERLOCK_CYC)) u_ilock_win (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run(cur.pair && (ch_a ^ ch_b)),
    .expired(ilock_exp)
  );

  ////////////////////////////////////////////////////////////////////////
  // energize decision

  assign start_ok = cur.cfg[CFG_AUTO] || cur.start_armed; // R5
  assign go = start_ok && act // R5
    && !(cur.cfg[CFG_INTERLOCK] && cur.ilock) // R6
    && !(cur.cfg[CFG_SYNC] && cur.sync_fail); // R7
  assign wr_fire = cur.aw_got && cur.w_got;

  ////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    next_ctl = cur;
    ev_set = '0;
    ev_clr = '0;
    // channel pair history; flags clear only once both channels drop
    if (act) begin
      next_ctl.pair = 1'b1;
    end else if (!ch_a && !ch_b) begin
      next_ctl.pair = 1'b0;
    end
    if (ilock_exp) begin
      next_ctl.ilock = 1'b1; // R18
    end else if (!ch_a && !ch_b) begin
      next_ctl.ilock = 1'b0;
    end
    if (sync_exp) begin
      next_ctl.sync_fail = 1'b1; // R7
    end else if (!ch_a && !ch_b) begin
      next_ctl.sync_fail = 1'b0;
    end
    // manual start arms only on a fresh press seen in run-off
    next_ctl.start_prev = start_s;
    if (cur.st != ST_RUN_OFF || cur.entry || !act) begin
      next_ctl.start_armed = 1'b0; // R12 R13
    end else if (start_s && !cur.start_prev) begin
      next_ctl.start_armed = 1'b1;
    end
    // operating states; power loss overrides everything
    if (!pg) begin
      next_ctl.st = ST_OFF; // R14
      next_ctl.entry = 1'b0;
    end else begin
      case (cur.st)
        ST_OFF: begin
          next_ctl.st = ST_INIT; // R3
        end
        ST_INIT: begin
          if (err || (st_done && !st_pass)) begin
            next_ctl.st = ST_ERROR; // R9
          end else if (st_done && st_pass && sw_exp) begin
            next_ctl.st = ST_RUN_OFF; // R4
            next_ctl.entry = 1'b1;
          end
        end
        ST_RUN_OFF: begin
          if (err) begin
            next_ctl.st = ST_ERROR; // R9
          end else if (cur.entry) begin
            next_ctl.entry = 1'b0; // R10
          end else if (go) begin
            next_ctl.st = ST_RUN_ON; // R5 R11 R17
          end
        end
        ST_RUN_ON: begin
          if (err) begin
            next_ctl.st = ST_ERROR; // R9
          end else if (!act) begin
            next_ctl.st = ST_RUN_OFF; // R8
            next_ctl.entry = 1'b1;
            ev_set[EV_TRIP] = 1'b1;
          end
        end
        ST_ERROR: begin
          next_ctl.st = ST_ERROR; // R15
        end
        default: begin
          next_ctl.st = ST_ERROR;
        end
      endcase
    end
    // event detection from state changes and a rising interlock flag
    if (next_ctl.st == ST_ERROR && cur.st != ST_ERROR) begin
      ev_set[EV_ERROR] = 1'b1;
    end
    if (next_ctl.st == ST_RUN_ON && cur.st != ST_RUN_ON) begin
      ev_set[EV_ENERGIZE] = 1'b1;
    end
    if (next_ctl.ilock && !cur.ilock) begin
      ev_set[EV_INTERLOCK] = 1'b1;
    end
    // write channels, taken in either order, one write in flight
    if (awvalid && awready) begin
      next_ctl.aw_got = 1'b1;
      next_ctl.aw = awaddr;
    end
    if (wvalid && wready) begin
      next_ctl.w_got = 1'b1;
      next_ctl.wd = wdata;
      next_ctl.ws = wstrb;
    end
    if (cur.bvalid && bready) begin
      next_ctl.bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_ctl.aw_got = 1'b0;
      next_ctl.w_got = 1'b0;
      next_ctl.bvalid = 1'b1;
      next_ctl.bresp = RESP_OKAY;
      case (cur.aw)
        ADDR_CONFIG: begin
          if (cur.st != ST_OFF) begin
            next_ctl.bresp = RESP_SLVERR; // R1
            ev_set[EV_REJECT] = 1'b1;
          end else if (cur.ws[0]) begin
            next_ctl.cfg = cur.wd[CFG_W-1:0]; // R1
          end
        end
        ADDR_STATUS: begin
          next_ctl.bresp = RESP_OKAY;
        end
        ADDR_IRQ_STAT: begin
          if (cur.ws[0]) begin
            ev_clr = cur.wd[NUM_EV-1:0];
          end
        end
        ADDR_IRQ_MASK: begin
          if (cur.ws[0]) begin
            next_ctl.mask = cur.wd[NUM_EV-1:0];
          end
        end
        default: begin
          next_ctl.bresp = RESP_SLVERR;
        end
      endcase
    end
    // a new event wins over a clear landing in the same cycle
    next_ctl.ev = (cur.ev & ~ev_clr) | ev_set;
    // read channel, answered one cycle after the address
    if (cur.rvalid && rready) begin
      next_ctl.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_ctl.rvalid = 1'b1;
      next_ctl.rresp = RESP_OKAY;
      case (araddr)
        ADDR_CONFIG: next_ctl.rdata = 32'(cur.cfg);
        ADDR_STATUS: next_ctl.rdata = 32'({cur.sync_fail, cur.ilock, act,
                                           cur.out_on, cur.st});
        ADDR_IRQ_STAT: next_ctl.rdata = 32'(cur.ev);
        ADDR_IRQ_MASK: next_ctl.rdata = 32'(cur.mask);
        default: begin
          next_ctl.rdata = 32'h0000_0000;
          next_ctl.rresp = RESP_SLVERR;
        end
      endcase
    end
    // output follows the registered state, so it never glitches
    next_ctl.out_on = (next_ctl.st == ST_RUN_ON); // R2
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cur <= '0;
      cur.st <= ST_OFF;
      cur.cfg <= CFG_RESET;
      cur.mask <= MASK_RESET;
    end else begin
      cur <= next_ctl;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign awready = !cur.aw_got && !cur.bvalid;
  assign wready = !cur.w_got && !cur.bvalid;
  assign bvalid = cur.bvalid;
  assign bresp = cur.bresp;
  assign arready = !cur.rvalid;
  assign rvalid = cur.rvalid;
  assign rdata = cur.rdata;
  assign rresp = cur.rresp;
  assign safety_out = cur.out_on; // R2
  assign irq = |(cur.ev & cur.mask);

  ////////////////////////////////////////////////////////////////////////
  // checks

  // cycles spent ready to energize without being energized
  logic [31:0] wait_cnt;
  always_ff @(posedge ref_clk) begin
    if (!rst_n || cur.st != ST_RUN_OFF || !go) begin
      wait_cnt <= 32'h0000_0000;
    end else begin
      wait_cnt <= wait_cnt + 32'h0000_0001;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_cfg_locked: assert property ( // R1
    wr_fire && cur.aw == ADDR_CONFIG && cur.st != ST_OFF
    |=> $stable(cur.cfg) && bresp == RESP_SLVERR && bvalid)
    else $error("config changed outside off state");
  a_out_only_run: assert property ( // R2
    safety_out |-> cur.st == ST_RUN_ON)
    else $error("output energized outside run state");
  a_power_init: assert property ( // R3
    cur.st == ST_OFF && pg |=> cur.st == ST_INIT && !safety_out)
    else $error("power up did not enter initialization");
  a_init_exit: assert property ( // R4
    cur.st == ST_RUN_OFF && $past(cur.st) == ST_INIT
    |-> $past(st_done) && $past(st_pass) && $past(sw_exp))
    else $error("initialization left without passing tests");
  a_energize_cause: assert property ( // R5 R16
    $rose(safety_out) |-> $past(act) && $past(start_ok)
    && !$past(no_s) && $past(nc_s))
    else $error("energized without start and activation");
  a_ilock_block: assert property ( // R6
    cur.st == ST_RUN_OFF && cur.cfg[CFG_INTERLOCK] && cur.ilock
    |=> !safety_out)
    else $error("energized during interlock condition");
  a_sync_block: assert property ( // R7
    cur.st == ST_RUN_OFF && cur.cfg[CFG_SYNC] && cur.sync_fail
    |=> !safety_out)
    else $error("energized after synchronization failure");
  a_trip_response: assert property ( // R8
    cur.st == ST_RUN_ON && pg && !err && !act
    |=> cur.st == ST_RUN_OFF && !safety_out ##1 !safety_out)
    else $error("trip did not de-energize");
  a_error_entry: assert property ( // R9
    pg && err && cur.st inside {ST_INIT, ST_RUN_OFF, ST_RUN_ON}
    |=> cur.st == ST_ERROR && !safety_out && cur.ev[EV_ERROR])
    else $error("error not entered");
  a_entry_sample: assert property ( // R10
    cur.st == ST_RUN_OFF && $past(cur.st) != ST_RUN_OFF
    |=> cur.st != ST_RUN_ON)
    else $error("decision taken on entry cycle");
  a_start_idle: assert property ( // R11
    (cur.st == ST_RUN_OFF && !cur.cfg[CFG_AUTO] && !start_s) [*2]
    |=> !safety_out)
    else $error("energized with start released");
  a_start_no_act: assert property ( // R12
    cur.st == ST_RUN_OFF && !act |=> !safety_out)
    else $error("energized with inputs deactivated");
  a_trip_disarm: assert property ( // R13
    $fell(safety_out) && cur.st == ST_RUN_OFF
    |-> !cur.start_armed ##1 !cur.start_armed)
    else $error("start still armed after trip");
  a_power_loss: assert property ( // R14
    !pg |=> cur.st == ST_OFF && !safety_out)
    else $error("power loss did not reach off state");
  a_error_sticky: assert property ( // R15
    cur.st == ST_ERROR && pg |=> cur.st == ST_ERROR)
    else $error("error left while powered");
  a_energize_limit: assert property ( // R17
    wait_cnt < 32'(ENERGIZE_LIMIT_CYC))
    else $error("energize delay exceeded");
  a_ilock_flag: assert property ( // R18
    $rose(cur.ilock) |-> $past(ilock_exp) && $past(ch_a ^ ch_b))
    else $error("interlock flagged without skew");

  c_energize: cover property (cur.st == ST_RUN_OFF ##1 cur.st == ST_RUN_ON);
  c_trip: cover property (cur.st == ST_RUN_ON ##1 cur.st == ST_RUN_OFF);
  c_reject: cover property ($rose(cur.ev[EV_REJECT]));
  c_error: cover property (cur.st == ST_RUN_ON ##1 cur.st == ST_ERROR);

endmodule
`default_nettype wire

/* tb/estop_contacts.sv */
// model of the emergency-stop contact pair and the start button
`timescale 1ns/1ps
`default_nettype none
module estop_contacts #(
  parameter int LAG = 12
)(
  input wire logic ref_clk, // system clock
  input wire logic cmd_a, // first contact closed
  input wire logic cmd_b, // second contact closed
  input wire logic cmd_press, // button held
  input wire logic slow, // second contact lags behind
  output logic normally_open_channel, // 0 = active
  output logic normally_closed_channel, // 1 = active
  output logic start_in // high = pressed
);
  logic a_q = 1'b0;
  logic b_q = 1'b0;
  logic press_q = 1'b0;
  int lag_cnt = 0;
  // contacts move just after the edge; slow mode models a sticky contact
  always @(posedge ref_clk) begin
    a_q <= cmd_a;
    press_q <= cmd_press;
    lag_cnt <= (slow && cmd_b != b_q) ? lag_cnt + 1 : 0;
    if (!slow || lag_cnt == LAG - 1) begin
      b_q <= cmd_b;
    end
  end
  // antivalent pair: open channel low and closed channel high when active
  assign normally_open_channel = !a_q;
  assign normally_closed_channel = b_q;
  assign start_in = press_q;
endmodule
`default_nettype wire

/* tb/safety_state_ctrl_bench.sv */
// self-checking bench of the safety state controller
`timescale 1ns/1ps
`default_nettype none
module safety_state_ctrl_bench;
  import safety_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, safety_out, irq;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  logic power_good = 1'b0, st_done = 1'b0, st_pass = 1'b0, err_in = 1'b0;
  logic act_a = 1'b0, act_b = 1'b0, press = 1'b0, slow = 1'b0;
  logic no_ch, nc_ch, start_pin;
  int errors = 0;
  int tests_run = 0;

  always #5 ref_clk = ~ref_clk;

  // short counts keep the run brief; expectations follow these values
  safety_state_ctrl #(.SWITCH_ON_CYC(20), .SYNC_CYC(8), .INTERLOCK_CYC(10))
  safety_state_ctrl_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .power_good(power_good), .selftest_done(st_done),
    .selftest_pass(st_pass), .error_detect(err_in),
    .normally_open_channel(no_ch), .normally_closed_channel(nc_ch),
    .start_in(start_pin), .safety_out(safety_out), .irq(irq)
  );

  estop_contacts estop_contacts_inst (
    .ref_clk(ref_clk), .cmd_a(act_a), .cmd_b(act_b), .cmd_press(press),
    .slow(slow), .normally_open_channel(no_ch),
    .normally_closed_channel(nc_ch), .start_in(start_pin)
  );

  ////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // both write halves offered together, each dropped once taken;
  // handshakes are judged on values settled 1 ns after the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_t, w_t, b_t;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      #1;
      aw_t = (awvalid === 1'b1) && (awready === 1'b1);
      w_t = (wvalid === 1'b1) && (wready === 1'b1);
      b_t = (bvalid === 1'b1);
      rs = bresp;
      @(posedge ref_clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end while (!b_t);
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    logic ar_t, r_t;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      #1;
      ar_t = (arvalid === 1'b1) && (arready === 1'b1);
      r_t = (rvalid === 1'b1);
      rd = rdata;
      rs = rresp;
      @(posedge ref_clk);
      if (ar_t) arvalid <= 1'b0;
    end while (!r_t);
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] exp);
    rdr(a);
    chk(rd & m, exp);
  endtask

  // state field and output pin, then realign to an edge for stimulus
  task automatic st(input logic [4:0] s, input logic o);
    rchk(ADDR_STATUS, 32'h1f, {27'h0, s});
    #1;
    chk({31'h0, safety_out}, {31'h0, o});
    @(posedge ref_clk);
  endtask

  task automatic close_out;
    if (errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // watchdog: the sequence needs well under two thousand cycles
  initial begin
    cyc(20000);
    errors++;
    close_out;
  end

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    cyc(3);
    rst_n <= 1'b1;
    cyc(1);
    rchk(ADDR_CONFIG, 32'h7, 32'h0);
    rchk(ADDR_IRQ_MASK, 32'h1f, 32'h0);
    st(ST_OFF, 1'b0);
    rdr(8'h10);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    wr(ADDR_IRQ_MASK, 32'h1f);
    wr(ADDR_CONFIG, 32'h0);
    chk({30'h0, rs}, {30'h0, RESP_OKAY});
    // power on, self-test passes at once but the delay still runs
    st_done <= 1'b1;
    st_pass <= 1'b1;
    power_good <= 1'b1;
    cyc(4);
    st(ST_INIT, 1'b0);
    cyc(30);
    st(ST_RUN_OFF, 1'b0);
    // configuration refused outside the off state
    wr(ADDR_CONFIG, 32'h1);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    rchk(ADDR_CONFIG, 32'h7, 32'h0);
    rchk(ADDR_IRQ_STAT, 32'h1f, 32'h04);
    #1 chk({31'h0, irq}, 32'h1);
    wr(ADDR_IRQ_MASK, 32'h1b);
    #1 chk({31'h0, irq}, 32'h0);
    wr(ADDR_IRQ_STAT, 32'h1f);
    wr(ADDR_IRQ_MASK, 32'h1f);
    rchk(ADDR_IRQ_STAT, 32'h1f, 32'h0);
    #1 chk({31'h0, irq}, 32'h0);
    // start without inputs, inputs without start, then both
    press <= 1'b1;
    cyc(8);
    st(ST_RUN_OFF, 1'b0);
    press <= 1'b0;
    act_a <= 1'b1;
    act_b <= 1'b1;
    cyc(8);
    st(ST_RUN_OFF, 1'b0);
    press <= 1'b1;
    cyc(8);
    st(ST_RUN_ON, 1'b1);
    // trip, then restart only after a fresh press
    act_a <= 1'b0;
    act_b <= 1'b0;
    cyc(6);
    st(ST_RUN_OFF, 1'b0);
    rchk(ADDR_IRQ_STAT, 32'h1f, 32'h09);
    act_a <= 1'b1;
    act_b <= 1'b1;
    cyc(8);
    st(ST_RUN_OFF, 1'b0);
    press <= 1'b0;
    cyc(3);
    press <= 1'b1;
    cyc(8);
    st(ST_RUN_ON, 1'b1);
    // fault is left only by a power cycle
    err_in <= 1'b1;
    cyc(5);
    st(ST_ERROR, 1'b0);
    err_in <= 1'b0;
    press <= 1'b0;
    cyc(5);
    st(ST_ERROR, 1'b0);
    power_good <= 1'b0;
    act_a <= 1'b0;
    act_b <= 1'b0;
    cyc(5);
    st(ST_OFF, 1'b0);
    // automatic start with interlock and synchronisation monitoring
    wr(ADDR_CONFIG, 32'h7);
    chk({30'h0, rs}, {30'h0, RESP_OKAY});
    power_good <= 1'b1;
    cyc(35);
    st(ST_RUN_OFF, 1'b0);
    act_a <= 1'b1;
    act_b <= 1'b1;
    cyc(8);
    st(ST_RUN_ON, 1'b1);
    act_a <= 1'b0;
    cyc(20);
    rchk(ADDR_STATUS, 32'h80, 32'h80);
    act_a <= 1'b1;
    cyc(8);
    st(ST_RUN_OFF, 1'b0);
    act_a <= 1'b0;
    act_b <= 1'b0;
    cyc(4);
    act_a <= 1'b1;
    act_b <= 1'b1;
    cyc(8);
    st(ST_RUN_ON, 1'b1);
    // second contact closes too late for the synchronisation window
    act_a <= 1'b0;
    act_b <= 1'b0;
    cyc(4);
    slow <= 1'b1;
    act_a <= 1'b1;
    act_b <= 1'b1;
    cyc(25);
    rchk(ADDR_STATUS, 32'h100, 32'h100);
    st(ST_RUN_OFF, 1'b0);
    act_a <= 1'b0;
    act_b <= 1'b0;
    slow <= 1'b0;
    cyc(4);
    act_a <= 1'b1;
    act_b <= 1'b1;
    cyc(8);
    st(ST_RUN_ON, 1'b1);
    // power loss from run, then a failing self-test
    power_good <= 1'b0;
    cyc(5);
    st(ST_OFF, 1'b0);
    st_pass <= 1'b0;
    power_good <= 1'b1;
    cyc(10);
    st(ST_ERROR, 1'b0);
    close_out;
  end
endmodule
`default_nettype wire
